// *** pkg/lcvr_params.svh ***
`ifndef LCVR_PARAMS_SVH
`define LCVR_PARAMS_SVH
// Byte offsets of the configuration words
`define LCVR_OFF_COMP 4'h0
`define LCVR_OFF_RAMP 4'h4
`define LCVR_OFF_SPLO 4'h8
`define LCVR_OFF_SPHI 4'hC
// Field positions
`define LCVR_ZERO_HI 7
`define LCVR_ZERO_LO 4
`define LCVR_GAIN_HI 3
`define LCVR_GAIN_LO 0
`define LCVR_RDIS_BIT 7
`define LCVR_RMAG_HI 4
`define LCVR_RMAG_LO 0
// Reset values of the ramp disable and set point fields
`define LCVR_RST_RDIS 1'h0
`define LCVR_RST_SPLO 8'h00
`define LCVR_RST_SPHI 2'h0
// AXI responses
`define LCVR_RESP_OKAY 2'h0
`define LCVR_RESP_SLVERR 2'h2
`endif

// *** pkg/lcvr_pkg.sv ***
`default_nettype none
package lcvr_pkg;
	typedef logic [7:0] lcvr_byte_t;
	typedef logic [9:0] lcvr_code_t;
endpackage : lcvr_pkg
`default_nettype wire

// *** src/lcvr_regs.sv ***
// How it works
// (R1) Compensation word: bits 7-4 zero frequency code, 3-0 gain code, both outputs.
// (R2) Ramp word bit 7 disables the slope ramp when one; resets to zero.
// (R3) Ramp word bits 6-5 read zero and ignore writes.
// (R4) Ramp word bits 4-0 hold ramp magnitude code computed by software.
// (R5) A 10-bit reference code is built from set point low and high words.
// (R6) Reference code is unsigned linear, 2 mV nominal per step.
// (R7) Set point low word is full 8-bit read/write, code bits 7-0.
// (R8) Set point high word stores only bits 1-0, code bits 9-8.
// (R9) Set point high bits 7-2 always read zero.
// (R10) Code is high two bits concatenated above low eight bits.
// (R11) Reset clears set point and ramp disable; other fields not reset.
// (R12) A write updates its output next edge; held until rewritten or reset.
`timescale 1ns/10ps
`default_nettype none
`include "lcvr_params.svh"
module lcvr_regs (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [3:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [3:0] o_comp_zero_freq_code,
	output logic [3:0] o_comp_gain_code,
	output logic o_ramp_disable,
	output logic [4:0] o_ramp_magnitude_code,
	output lcvr_pkg::lcvr_code_t o_reference_dac_code
);
	logic aw_held_q;
	logic [3:0] aw_addr_q;
	logic w_held_q;
	logic [7:0] w_data_q;
	logic w_lane_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic wr_hit;
	lcvr_pkg::lcvr_byte_t comp_q;
	logic [4:0] rmag_q;
	logic rdis_q;
	lcvr_pkg::lcvr_byte_t splo_q;
	logic [1:0] sphi_q;

	// Address and data accepted independently; held until the write is done, none taken until the response drains
	assign o_awready = !aw_held_q && !bvalid_q;
	assign o_wready = !w_held_q && !bvalid_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wr_hit = do_write && w_lane_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
		end else if (i_awvalid && o_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= i_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	// Only byte lane 0 carries data; other lanes are ignored
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			w_held_q <= 1'b0;
			w_data_q <= 8'h00;
			w_lane_q <= 1'b0;
		end else if (i_wvalid && o_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= i_wdata[7:0];
			w_lane_q <= i_wstrb[0];
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer SLVERR
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= (aw_addr_q[1:0] == 2'h0) ? `LCVR_RESP_OKAY : `LCVR_RESP_SLVERR;
		end else if (bvalid_q && i_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;

	// Compensation and magnitude fields have no reset value, as in silicon
	always_ff @(posedge i_clk) begin
		if (wr_hit && aw_addr_q == `LCVR_OFF_COMP) begin
			comp_q <= w_data_q; // R1 R12
		end
		if (wr_hit && aw_addr_q == `LCVR_OFF_RAMP) begin
			rmag_q <= w_data_q[`LCVR_RMAG_HI:`LCVR_RMAG_LO]; // R4 R11
		end
	end

	// Ramp disable and set point words cleared at power-on
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdis_q <= `LCVR_RST_RDIS; // R11
			splo_q <= `LCVR_RST_SPLO; // R11
			sphi_q <= `LCVR_RST_SPHI; // R11
		end else if (wr_hit) begin
			if (aw_addr_q == `LCVR_OFF_RAMP) begin
				rdis_q <= w_data_q[`LCVR_RDIS_BIT]; // R2 R3
			end
			if (aw_addr_q == `LCVR_OFF_SPLO) begin
				splo_q <= w_data_q; // R7 R12
			end
			if (aw_addr_q == `LCVR_OFF_SPHI) begin
				sphi_q <= w_data_q[1:0]; // R8 R9
			end
		end
	end

	// Static loop outputs straight from the storage flops
	assign o_comp_zero_freq_code = comp_q[`LCVR_ZERO_HI:`LCVR_ZERO_LO]; // R1
	assign o_comp_gain_code = comp_q[`LCVR_GAIN_HI:`LCVR_GAIN_LO]; // R1
	assign o_ramp_disable = rdis_q; // R2
	assign o_ramp_magnitude_code = rmag_q; // R4
	assign o_reference_dac_code = {sphi_q, splo_q}; // R5 R6 R10

	// Read channel: one read at a time, answer one cycle after the address
	assign o_arready = !rvalid_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end else if (i_arvalid && o_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= `LCVR_RESP_OKAY;
			unique case (i_araddr)
				`LCVR_OFF_COMP: rdata_q <= {24'h000000, comp_q};
				`LCVR_OFF_RAMP: rdata_q <= {24'h000000, rdis_q, 2'h0, rmag_q}; // R3
				`LCVR_OFF_SPLO: rdata_q <= {24'h000000, splo_q}; // R7
				`LCVR_OFF_SPHI: rdata_q <= {24'h000000, 6'h00, sphi_q}; // R9
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= `LCVR_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && i_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;

	// Checks on what this block drives; bus inputs only pick the cycles.
	// Compensation and magnitude fields start unknown by design, so no check
	// reads them before software has written them; an early read would trip
	// on a legal unknown rather than on a fault.

	// Ramp disable follows the last accepted write one edge later
	a_ramp_dis_write: assert property (@(posedge i_clk) disable iff (i_rst) // R2
		(wr_hit && aw_addr_q == `LCVR_OFF_RAMP)
		|=> (o_ramp_disable == $past(w_data_q[`LCVR_RDIS_BIT])))
		else $error("ramp disable not updated");

	// Unused ramp bits read back as zero
	a_ramp_unimpl_read: assert property (@(posedge i_clk) disable iff (i_rst) // R3
		(i_arvalid && o_arready && i_araddr == `LCVR_OFF_RAMP)
		|=> (o_rdata[6:5] == 2'h0))
		else $error("ramp bits 6-5 not zero");

	// Set point high word shows only its two stored bits
	a_sphi_unimpl_read: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(i_arvalid && o_arready && i_araddr == `LCVR_OFF_SPHI)
		|=> (o_rdata[7:2] == 6'h00))
		else $error("set point high upper bits not zero");

	// High word lands in code bits 9-8
	a_code_concat: assert property (@(posedge i_clk) disable iff (i_rst) // R8 R10
		(wr_hit && aw_addr_q == `LCVR_OFF_SPHI)
		|=> (o_reference_dac_code[9:8] == $past(w_data_q[1:0])))
		else $error("code high bits wrong");

	// Low word lands in code bits 7-0
	a_splo_write: assert property (@(posedge i_clk) disable iff (i_rst) // R5 R7
		(wr_hit && aw_addr_q == `LCVR_OFF_SPLO)
		|=> (o_reference_dac_code[7:0] == $past(w_data_q)))
		else $error("code low bits wrong");

	// Zero frequency above gain, both from one write
	a_comp_write: assert property (@(posedge i_clk) disable iff (i_rst) // R1
		(wr_hit && aw_addr_q == `LCVR_OFF_COMP)
		|=> ({o_comp_zero_freq_code, o_comp_gain_code} == $past(w_data_q)))
		else $error("compensation codes wrong");

	// Magnitude code taken unchanged from the low five bits
	a_rmag_write: assert property (@(posedge i_clk) disable iff (i_rst) // R4
		(wr_hit && aw_addr_q == `LCVR_OFF_RAMP)
		|=> (o_ramp_magnitude_code == $past(w_data_q[`LCVR_RMAG_HI:`LCVR_RMAG_LO])))
		else $error("ramp magnitude wrong");

	// A glitch on the reference would move the output voltage, so hold it
	a_code_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R6 R12
		!(do_write && (aw_addr_q == `LCVR_OFF_SPLO || aw_addr_q == `LCVR_OFF_SPHI))
		|=> $stable(o_reference_dac_code))
		else $error("reference code changed without write");

	// Power-on leaves the reference at zero and the ramp enabled
	a_reset_clear: assert property (@(posedge i_clk) // R11
		$fell(i_rst)
		|-> (o_reference_dac_code == 10'h000 && !o_ramp_disable))
		else $error("reset values wrong");

	// Ramp disable moves only on a ramp write
	a_rdis_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		!(wr_hit && aw_addr_q == `LCVR_OFF_RAMP)
		|=> $stable(o_ramp_disable))
		else $error("ramp disable changed without write");

	// Read of the high word returns the stored code bits
	a_sphi_read: assert property (@(posedge i_clk) disable iff (i_rst) // R8
		(i_arvalid && o_arready && i_araddr == `LCVR_OFF_SPHI)
		|=> (o_rdata[1:0] == $past(o_reference_dac_code[9:8])))
		else $error("set point high read wrong");

	// Read of the low word returns the stored code bits
	a_splo_read: assert property (@(posedge i_clk) disable iff (i_rst) // R7
		(i_arvalid && o_arready && i_araddr == `LCVR_OFF_SPLO)
		|=> (o_rdata[7:0] == $past(o_reference_dac_code[7:0])))
		else $error("set point low read wrong");

	// Read of the ramp word shows the disable bit in place
	a_ramp_dis_read: assert property (@(posedge i_clk) disable iff (i_rst) // R2
		(i_arvalid && o_arready && i_araddr == `LCVR_OFF_RAMP)
		|=> (o_rdata[`LCVR_RDIS_BIT] == $past(o_ramp_disable)))
		else $error("ramp disable read wrong");

	// Only byte lane 0 carries register data
	a_rdata_upper_zero: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(i_arvalid && o_arready)
		|=> (o_rdata[31:8] == 24'h000000))
		else $error("read upper bytes not zero");

	// Write answer stands until the master takes it
	a_bvalid_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(o_bvalid && !i_bready)
		|=> (o_bvalid && $stable(o_bresp)))
		else $error("write answer dropped early");

	// Read answer stands until the master takes it
	a_rvalid_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(o_rvalid && !i_rready)
		|=> (o_rvalid && $stable(o_rresp)))
		else $error("read answer dropped early");

	// Taken write answer clears so the next write can start
	a_bvalid_drop: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(o_bvalid && i_bready)
		|=> !o_bvalid)
		else $error("write answer not cleared");

	// Taken read answer clears so the next read can start
	a_rvalid_drop: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(o_rvalid && i_rready)
		|=> !o_rvalid)
		else $error("read answer not cleared");

	// Write answer one edge after address and data are both held
	a_write_answer: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		do_write
		|=> o_bvalid)
		else $error("write answer late");

	// Read answer one edge after the address is taken
	a_read_answer: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(i_arvalid && o_arready)
		|=> o_rvalid)
		else $error("read answer late");

	// Misaligned write offsets report an error; only the response is checked here
	a_bresp_unaligned: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(do_write && aw_addr_q[1:0] != 2'h0)
		|=> (o_bresp == `LCVR_RESP_SLVERR))
		else $error("misaligned write not refused");

	// Aligned writes always answer OKAY
	a_bresp_okay: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(do_write && aw_addr_q[1:0] == 2'h0)
		|=> (o_bresp == `LCVR_RESP_OKAY))
		else $error("aligned write refused");

	// A write with lane 0 masked must not touch the loop
	a_lane_off: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(do_write && !w_lane_q)
		|=> ($stable(o_reference_dac_code) && $stable(o_ramp_disable)))
		else $error("masked write changed state");

	// Unmapped reads return zero data with an error
	a_rresp_unmapped: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(i_arvalid && o_arready && i_araddr[1:0] != 2'h0)
		|=> (o_rresp == `LCVR_RESP_SLVERR && o_rdata == 32'h00000000))
		else $error("unmapped read not refused");

	// Mapped reads answer OKAY
	a_rresp_okay: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(i_arvalid && o_arready && i_araddr[1:0] == 2'h0)
		|=> (o_rresp == `LCVR_RESP_OKAY))
		else $error("mapped read refused");

	// No bus answer survives a reset
	a_reset_valids: assert property (@(posedge i_clk) // R11
		$fell(i_rst)
		|-> (!o_bvalid && !o_rvalid))
		else $error("bus answer left after reset");

	// Low word write leaves the high code bits alone
	a_splo_only: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		(wr_hit && aw_addr_q == `LCVR_OFF_SPLO)
		|=> (o_reference_dac_code[9:8] == $past(o_reference_dac_code[9:8])))
		else $error("low write moved high bits");

	// High word write leaves the low code bits alone
	a_sphi_only: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		(wr_hit && aw_addr_q == `LCVR_OFF_SPHI)
		|=> (o_reference_dac_code[7:0] == $past(o_reference_dac_code[7:0])))
		else $error("high write moved low bits");
endmodule : lcvr_regs
`default_nettype wire

// *** testbench/loop_comp_and_vref_setpoint_regs_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lcvr_params.svh"
module loop_comp_and_vref_setpoint_regs_test;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [3:0] i_awaddr = 4'h0, i_wstrb = 4'h0, i_araddr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ramp_disable;
	logic [1:0] o_bresp, o_rresp, resp;
	logic [31:0] o_rdata, rd;
	logic [3:0] o_comp_zero_freq_code, o_comp_gain_code;
	logic [4:0] o_ramp_magnitude_code;
	lcvr_pkg::lcvr_code_t o_reference_dac_code;
	int bad_count = 0;
	int total_checks = 0;
	lcvr_regs i_dut (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
		.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_comp_zero_freq_code, .o_comp_gain_code,
		.o_ramp_disable, .o_ramp_magnitude_code, .o_reference_dac_code);
	// Free-running core clock
	always #5 i_clk = ~i_clk;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Ready sampled at negedge, stable until the taking edge
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw;
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= s;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do begin
			@(negedge i_clk);
			ta = i_awvalid & o_awready;
			tw = i_wvalid & o_wready;
			@(posedge i_clk);
			if (ta) i_awvalid <= 1'h0;
			if (tw) i_wvalid <= 1'h0;
		end while ((i_awvalid && !ta) || (i_wvalid && !tw));
		do @(negedge i_clk); while (!o_bvalid);
		resp = o_bresp;
		@(posedge i_clk);
		i_bready <= 1'h0;
		// Spare edge so the next call never re-drives in this step
		@(posedge i_clk);
	endtask : wr
	task rd_reg(input logic [3:0] a);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do @(negedge i_clk); while (!o_arready);
		@(posedge i_clk);
		i_arvalid <= 1'h0;
		do @(negedge i_clk); while (!o_rvalid);
		rd = o_rdata;
		resp = o_rresp;
		@(posedge i_clk);
		i_rready <= 1'h0;
		@(posedge i_clk);
	endtask : rd_reg
	task t_reset;
		chk("rdis", 32'h0, o_ramp_disable);
		chk("ref", 32'h0, o_reference_dac_code);
		rd_reg(`LCVR_OFF_SPHI);
		chk("sphi", 32'h0, rd);
	endtask : t_reset
	task t_comp;
		wr(`LCVR_OFF_COMP, 32'hC3, 4'hF);
		chk("bresp", `LCVR_RESP_OKAY, resp);
		chk("zero", 32'hC, o_comp_zero_freq_code);
		chk("gain", 32'h3, o_comp_gain_code);
		rd_reg(`LCVR_OFF_COMP);
		chk("comp", 32'hC3, rd);
		chk("rresp", `LCVR_RESP_OKAY, resp);
	endtask : t_comp
	task t_ramp;
		wr(`LCVR_OFF_RAMP, 32'hFF, 4'h1);
		chk("rdis", 32'h1, o_ramp_disable);
		chk("rmag", 32'h1F, o_ramp_magnitude_code);
		rd_reg(`LCVR_OFF_RAMP);
		chk("ramp", 32'h9F, rd);
		wr(`LCVR_OFF_RAMP, 32'h0A, 4'h1);
		chk("rdis", 32'h0, o_ramp_disable);
		chk("rmag", 32'h0A, o_ramp_magnitude_code);
	endtask : t_ramp
	task t_setpt;
		wr(`LCVR_OFF_SPLO, 32'h5A, 4'h1);
		wr(`LCVR_OFF_SPHI, 32'hFF, 4'h1);
		chk("ref", 32'h35A, o_reference_dac_code);
		rd_reg(`LCVR_OFF_SPHI);
		chk("sphi", 32'h3, rd);
		rd_reg(`LCVR_OFF_SPLO);
		chk("splo", 32'h5A, rd);
		chk("zero", 32'hC, o_comp_zero_freq_code);
	endtask : t_setpt
	// Refused and lane-masked accesses must leave stored state alone
	task t_err;
		rd_reg(4'h1);
		chk("rresp", `LCVR_RESP_SLVERR, resp);
		chk("rdata", 32'h0, rd);
		wr(4'h9, 32'h00, 4'h1);
		chk("bresp", `LCVR_RESP_SLVERR, resp);
		wr(`LCVR_OFF_SPLO, 32'h00, 4'h0);
		chk("bresp", `LCVR_RESP_OKAY, resp);
		chk("ref", 32'h35A, o_reference_dac_code);
	endtask : t_err
	// Late bready and rready: answers must stand until taken
	task t_stall;
		i_awaddr <= `LCVR_OFF_SPLO;
		i_wdata <= 32'h000000A5;
		i_wstrb <= 4'h1;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		do begin
			@(posedge i_clk);
			if (o_awready) i_awvalid <= 1'h0;
			if (o_wready) i_wvalid <= 1'h0;
		end while ((i_awvalid && !o_awready) || (i_wvalid && !o_wready));
		repeat (3) @(posedge i_clk);
		chk("bvalid", 32'h1, o_bvalid);
		chk("bresp", `LCVR_RESP_OKAY, o_bresp);
		chk("ref", 32'h3A5, o_reference_dac_code);
		i_bready <= 1'h1;
		@(posedge i_clk);
		i_bready <= 1'h0;
		i_araddr <= `LCVR_OFF_SPLO;
		i_arvalid <= 1'h1;
		do @(posedge i_clk); while (!o_arready);
		i_arvalid <= 1'h0;
		repeat (3) @(posedge i_clk);
		chk("rvalid", 32'h1, o_rvalid);
		chk("rdata", 32'hA5, o_rdata);
		chk("rresp", `LCVR_RESP_OKAY, o_rresp);
		i_rready <= 1'h1;
		@(posedge i_clk);
		i_rready <= 1'h0;
		@(posedge i_clk);
		chk("rvalid", 32'h0, o_rvalid);
		chk("bvalid", 32'h0, o_bvalid);
	endtask : t_stall
	task t_rst2;
		wr(`LCVR_OFF_RAMP, 32'h80, 4'h1);
		chk("rdis", 32'h1, o_ramp_disable);
		i_rst <= 1'h1;
		@(posedge i_clk);
		i_rst <= 1'h0;
		@(posedge i_clk);
		chk("rdis", 32'h0, o_ramp_disable);
		chk("ref", 32'h0, o_reference_dac_code);
	endtask : t_rst2
	task report_and_stop;
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'h0;
		@(posedge i_clk);
		t_reset();
		t_comp();
		t_ramp();
		t_setpt();
		t_err();
		t_stall();
		t_rst2();
		report_and_stop();
	end
	// Watchdog: under a hundred cycles expected, limit 2000 cycles
	initial begin
		#20000;
		bad_count++;
		report_and_stop();
	end
endmodule : loop_comp_and_vref_setpoint_regs_test
`default_nettype wire
